/* rds_pkg.sv */
/*
  shared constants and types of the rail enable delay sequencer.
  assumes a 50 MHz system clock and 8-bit registers at their fixed offsets.
*/
package rds_pkg;

  // ****************************************
  // clock and timebase
  // ****************************************
  localparam int unsigned RDS_CLK_PERIOD_NS = 20;
  localparam int unsigned RDS_STEP_TIME_NS = 500000;
  localparam int unsigned RDS_STEP_CYCLES = RDS_STEP_TIME_NS / RDS_CLK_PERIOD_NS;
  localparam int unsigned RDS_DOUBLE_FACTOR = 2;
  localparam int unsigned RDS_CYC_W = 17;
  localparam int unsigned RDS_SPAN_W = 21;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] RDS_SECOND_BUCK_DELAY_OFS = 8'h0a;
  localparam logic [7:0] RDS_BOOST_DELAY_OFS = 8'h0b;
  localparam logic [7:0] RDS_DELAY_RESET = 8'h00;
  localparam logic [7:0] RDS_UNMAPPED_READ = 8'h00;
  localparam int unsigned RDS_OFF_CODE_LSB = 4;
  localparam int unsigned RDS_ON_CODE_LSB = 0;
  localparam logic [3:0] RDS_CODE_NONE = 4'h0;

  // ****************************************
  // pin select codes
  // ****************************************
  localparam logic [1:0] RDS_PIN_NONE = 2'h0;
  localparam logic [1:0] RDS_PIN_ONE = 2'h1;
  localparam logic [1:0] RDS_PIN_TWO = 2'h2;
  localparam logic [1:0] RDS_PIN_THREE = 2'h3;

  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic [3:0] off_code;
    logic [3:0] on_code;
  } rds_delay_type;

  typedef enum logic [1:0] {
    RDS_OFF,
    RDS_WAIT_ON,
    RDS_ON,
    RDS_WAIT_OFF
  } rds_rail_state_type;

endpackage : rds_pkg

/* rds_rail_delay.sv */
/*
  one rail: delays the enable after each edge of its control level.
  assumes ctrl is synchronous to clk_sys and the codes are stable while waiting.
*/
`timescale 1ns/1ps
module rds_rail_delay
  import rds_pkg::*;
#(
  parameter int unsigned STEP_CYCLES = RDS_STEP_CYCLES
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ctrl,
  input wire rds_delay_type delay,
  input wire logic dbl,
  output logic rail_en
);

  // ****************************************
  // sequencer
  // ****************************************
  rds_rail_state_type state, next_state;
  logic [RDS_CYC_W-1:0] cyc, next_cyc;
  logic [3:0] steps, next_steps;
  logic ctrl_q, next_ctrl_q;
  logic next_rail_en;
  logic [RDS_CYC_W-1:0] step_len;
  logic step_done;

  assign step_len = dbl ? RDS_CYC_W'(RDS_DOUBLE_FACTOR * STEP_CYCLES) : RDS_CYC_W'(STEP_CYCLES);
  assign step_done = (cyc == step_len - RDS_CYC_W'(1));

  always_comb begin
    next_state = state;
    next_cyc = cyc;
    next_steps = steps;
    next_ctrl_q = ctrl;
    unique case (state)
      RDS_OFF: begin
        if (ctrl && !ctrl_q) begin
          next_cyc = '0;
          next_steps = delay.on_code;
          next_state = (delay.on_code == RDS_CODE_NONE) ? RDS_ON : RDS_WAIT_ON;
        end
      end
      RDS_WAIT_ON: begin
        // a control that drops mid-wait aborts the start
        if (!ctrl) begin
          next_state = RDS_OFF;
        end else if (step_done) begin
          next_cyc = '0;
          next_steps = steps - 4'h1;
          if (steps == 4'h1) begin
            next_state = RDS_ON;
          end
        end else begin
          next_cyc = cyc + RDS_CYC_W'(1);
        end
      end
      RDS_ON: begin
        if (!ctrl && ctrl_q) begin
          next_cyc = '0;
          next_steps = delay.off_code;
          next_state = (delay.off_code == RDS_CODE_NONE) ? RDS_OFF : RDS_WAIT_OFF;
        end
      end
      RDS_WAIT_OFF: begin
        if (ctrl) begin
          next_state = RDS_ON;
        end else if (step_done) begin
          next_cyc = '0;
          next_steps = steps - 4'h1;
          if (steps == 4'h1) begin
            next_state = RDS_OFF;
          end
        end else begin
          next_cyc = cyc + RDS_CYC_W'(1);
        end
      end
    endcase
    next_rail_en = (next_state == RDS_ON) || (next_state == RDS_WAIT_OFF);
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state <= RDS_OFF;
      cyc <= '0;
      steps <= 4'h0;
      ctrl_q <= 1'b0;
      rail_en <= 1'b0;
    end else begin
      state <= next_state;
      cyc <= next_cyc;
      steps <= next_steps;
      ctrl_q <= next_ctrl_q;
      rail_en <= next_rail_en;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  logic [RDS_SPAN_W-1:0] since_edge, exp_span;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      since_edge <= '0;
      exp_span <= '0;
    end else begin
      if (ctrl != ctrl_q) begin
        since_edge <= RDS_SPAN_W'(1);
        exp_span <= RDS_SPAN_W'(ctrl ? delay.on_code : delay.off_code) * RDS_SPAN_W'(step_len);
      end else if (since_edge != '1) begin
        since_edge <= since_edge + RDS_SPAN_W'(1);
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  a_on_delay_exact: assert property ($rose(rail_en) |-> since_edge == exp_span + RDS_SPAN_W'(1))
    else $error("rail enabled at wrong time after rising control");
  a_off_delay_exact: assert property ($fell(rail_en) |-> since_edge == exp_span + RDS_SPAN_W'(1))
    else $error("rail disabled at wrong time after falling control");
  a_zero_code_now: assert property ((state == RDS_OFF && ctrl && !ctrl_q && delay.on_code == RDS_CODE_NONE) |=> rail_en)
    else $error("zero start-up code did not enable at once");
  a_double_base: assert property ((state == RDS_WAIT_ON && ctrl && dbl && cyc == RDS_CYC_W'(STEP_CYCLES - 1)) |=> cyc == RDS_CYC_W'(STEP_CYCLES))
    else $error("doubled timebase wrapped at single step");
  a_wait_holds_off: assert property (state == RDS_WAIT_ON |-> !rail_en ##1 (state != RDS_WAIT_OFF))
    else $error("rail on while start-up delay runs");

  c_delayed_start: cover property ((state == RDS_WAIT_ON) ##1 (state == RDS_ON));
  c_delayed_stop: cover property ((state == RDS_WAIT_OFF) ##1 (state == RDS_OFF));
  c_abort_start: cover property ((state == RDS_WAIT_ON) ##1 (state == RDS_OFF));

endmodule : rds_rail_delay

/* rds_top.sv */
/*
  rail enable delay sequencer: delay registers for the second buck and the boost.
  assumes the register port and otp load come from on-chip logic on clk_sys and
  the enable pins arrive asynchronously.
*/
// What this block does
// - second buck turns on after its start-up delay from control rising.
// - second buck turns off after its shutdown delay from control falling.
// - boost turns on after its start-up delay from control rising.
// - boost turns off after its shutdown delay from control falling.
// - code zero is no delay, one is 0.5 ms, fifteen 7.5 ms.
// - global select doubles the step: one is 1 ms, fifteen 15 ms.
// - delay registers at 0xa and 0xb, 8-bit read-write, reset zero.
// - start-up loads every delay field default from otp memory.
// - boost control is its enable bit, optionally anded with a chosen pin.
`timescale 1ns/1ps
module rds_top
  import rds_pkg::*;
#(
  parameter int unsigned STEP_CYCLES = RDS_STEP_CYCLES
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic otp_load,
  input wire rds_delay_type otp_second_buck_delay,
  input wire rds_delay_type otp_boost_delay,
  input wire logic delay_sel,
  input wire logic second_buck_ctrl,
  input wire logic boost_en_bit,
  input wire logic [1:0] boost_pin_ctrl,
  input wire logic enable_pin_one,
  input wire logic enable_pin_two,
  input wire logic enable_pin_three,
  output logic second_buck_enable,
  output logic boost_enable
);

  // ****************************************
  // delay registers
  // ****************************************
  rds_delay_type second_buck_sequence_delay, next_second_buck_sequence_delay;
  rds_delay_type boost_sequence_delay, next_boost_sequence_delay;
  logic [7:0] next_reg_rdata;

  always_comb begin
    next_second_buck_sequence_delay = second_buck_sequence_delay;
    next_boost_sequence_delay = boost_sequence_delay;
    next_reg_rdata = reg_rdata;
    if (otp_load) begin
      next_second_buck_sequence_delay = otp_second_buck_delay;
      next_boost_sequence_delay = otp_boost_delay;
    end else if (reg_wr) begin
      if (reg_addr == RDS_SECOND_BUCK_DELAY_OFS) begin
        next_second_buck_sequence_delay = rds_delay_type'(reg_wdata);
      end
      if (reg_addr == RDS_BOOST_DELAY_OFS) begin
        next_boost_sequence_delay = rds_delay_type'(reg_wdata);
      end
    end
    if (reg_rd) begin
      if (reg_addr == RDS_SECOND_BUCK_DELAY_OFS) begin
        next_reg_rdata = second_buck_sequence_delay;
      end else if (reg_addr == RDS_BOOST_DELAY_OFS) begin
        next_reg_rdata = boost_sequence_delay;
      end else begin
        next_reg_rdata = RDS_UNMAPPED_READ;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      second_buck_sequence_delay <= rds_delay_type'(RDS_DELAY_RESET);
      boost_sequence_delay <= rds_delay_type'(RDS_DELAY_RESET);
      reg_rdata <= RDS_UNMAPPED_READ;
    end else begin
      second_buck_sequence_delay <= next_second_buck_sequence_delay;
      boost_sequence_delay <= next_boost_sequence_delay;
      reg_rdata <= next_reg_rdata;
    end
  end

  // ****************************************
  // enable pin synchronisers
  // ****************************************
  // three stages; the filtered level moves only when stages two and three agree,
  // which also rejects a single-cycle glitch
  logic [2:0] pin_s1, pin_s2, pin_s3, pin_filt, next_pin_filt;
  logic next_boost_ctrl, boost_ctrl;
  logic pin_gate;

  always_comb begin
    next_pin_filt = (pin_s2 & pin_s3) | (pin_filt & (pin_s2 ^ pin_s3));
    unique case (boost_pin_ctrl)
      RDS_PIN_NONE: pin_gate = 1'b1;
      RDS_PIN_ONE: pin_gate = pin_filt[0];
      RDS_PIN_TWO: pin_gate = pin_filt[1];
      RDS_PIN_THREE: pin_gate = pin_filt[2];
    endcase
    next_boost_ctrl = boost_en_bit & pin_gate;
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pin_s1 <= 3'h0;
      pin_s2 <= 3'h0;
      pin_s3 <= 3'h0;
      pin_filt <= 3'h0;
      boost_ctrl <= 1'b0;
    end else begin
      pin_s1 <= {enable_pin_three, enable_pin_two, enable_pin_one};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_filt <= next_pin_filt;
      boost_ctrl <= next_boost_ctrl;
    end
  end

  // ****************************************
  // rails
  // ****************************************
  // both rails share the step select; a change during a wait stretches or cuts it,
  // so software should move the select only while both rails are settled
  // second buck rail
  rds_rail_delay #(
    .STEP_CYCLES(STEP_CYCLES)
  ) u_second_buck (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .ctrl(second_buck_ctrl),
    .delay(second_buck_sequence_delay),
    .dbl(delay_sel),
    .rail_en(second_buck_enable)
  );

  rds_rail_delay #(
    .STEP_CYCLES(STEP_CYCLES)
  ) u_boost (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .ctrl(boost_ctrl),
    .delay(boost_sequence_delay),
    .dbl(delay_sel),
    .rail_en(boost_enable)
  );

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  a_buck_reg_write: assert property ((reg_wr && !otp_load && reg_addr == RDS_SECOND_BUCK_DELAY_OFS)
      |=> second_buck_sequence_delay == $past(reg_wdata))
    else $error("second buck delay write not stored");
  a_boost_reg_read: assert property ((reg_rd && reg_addr == RDS_BOOST_DELAY_OFS)
      |=> reg_rdata == $past(boost_sequence_delay))
    else $error("boost delay readback wrong");
  a_unmapped_zero: assert property ((reg_rd && reg_addr != RDS_SECOND_BUCK_DELAY_OFS
      && reg_addr != RDS_BOOST_DELAY_OFS) |=> reg_rdata == RDS_UNMAPPED_READ)
    else $error("unmapped read not zero");
  a_otp_defaults: assert property (otp_load |=> (second_buck_sequence_delay == $past(otp_second_buck_delay))
      && (boost_sequence_delay == $past(otp_boost_delay)))
    else $error("otp defaults not loaded");
  a_boost_gate: assert property ((!boost_en_bit || (boost_pin_ctrl == RDS_PIN_ONE && !pin_filt[0]))
      |=> !boost_ctrl)
    else $error("boost control ignores bit or pin");
  a_boost_bit_only: assert property ((boost_en_bit && boost_pin_ctrl == RDS_PIN_NONE) |=> boost_ctrl)
    else $error("boost control not bit alone");

  // stages two and three must agree before the filtered pin level moves
  a_filter_holds: assert property ((pin_s2[0] != pin_s3[0])
      |=> pin_filt[0] == $past(pin_filt[0]))
    else $error("pin filter moved while stages disagree");
  a_filter_settles: assert property ((pin_s2 == pin_s3) |=> pin_filt == $past(pin_s3))
    else $error("pin filter missed an agreed level");
  a_boost_pin_pass: assert property ((boost_en_bit && boost_pin_ctrl == RDS_PIN_ONE)
      && pin_filt[0] |=> boost_ctrl)
    else $error("boost control blocked by a high pin");
  a_boost_pin_two: assert property ((boost_pin_ctrl == RDS_PIN_TWO && !pin_filt[1])
      |=> !boost_ctrl)
    else $error("boost control ignores pin two");
  a_boost_pin_three: assert property ((boost_pin_ctrl == RDS_PIN_THREE && !pin_filt[2])
      |=> !boost_ctrl)
    else $error("boost control ignores pin three");

  // register contents move only on a mapped write or an otp load
  a_boost_reg_write: assert property ((reg_wr && !otp_load && reg_addr == RDS_BOOST_DELAY_OFS)
      |=> boost_sequence_delay == $past(reg_wdata))
    else $error("boost delay write not stored");
  a_buck_reg_read: assert property ((reg_rd && reg_addr == RDS_SECOND_BUCK_DELAY_OFS)
      |=> reg_rdata == $past(second_buck_sequence_delay))
    else $error("second buck delay readback wrong");
  a_regs_hold: assert property ((!otp_load && !reg_wr) |=> $stable(boost_sequence_delay)
      && $stable(second_buck_sequence_delay))
    else $error("delay register moved without a write");
  a_wr_other_ignored: assert property ((reg_wr && !otp_load
      && reg_addr != RDS_SECOND_BUCK_DELAY_OFS && reg_addr != RDS_BOOST_DELAY_OFS)
      |=> $stable(second_buck_sequence_delay) && $stable(boost_sequence_delay))
    else $error("write to an unmapped offset changed a delay");
  a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  a_otp_beats_write: assert property ((otp_load && reg_wr)
      |=> boost_sequence_delay == $past(otp_boost_delay))
    else $error("register write beat the otp load");

  c_otp_then_write: cover property (otp_load ##[1:4] (reg_wr && reg_addr == RDS_BOOST_DELAY_OFS));
  c_pin_gated_boost: cover property ((boost_pin_ctrl == RDS_PIN_ONE) && $rose(boost_enable));

endmodule : rds_top

/* testbench.sv */
/*
  self-checking bench of the rail enable delay sequencer top.
  assumes rds_pkg and rds_top are compiled first; the step is cut to 4 cycles.
*/
`timescale 1ns/1ps
module testbench;
  import rds_pkg::*;
  // short step keeps the 15-code waits to at most 120 cycles
  localparam int unsigned STEP = 4;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic otp_load = 1'b0;
  rds_delay_type otp_second_buck_delay = 8'h00;
  rds_delay_type otp_boost_delay = 8'h00;
  logic delay_sel = 1'b0;
  logic second_buck_ctrl = 1'b0;
  logic boost_en_bit = 1'b0;
  logic [1:0] boost_pin_ctrl = 2'h0;
  logic [2:0] pins = 3'h0;
  logic second_buck_enable;
  logic boost_enable;
  logic [3:0] codes [5] = '{4'h0, 4'h1, 4'hf, 4'h6, 4'h1};
  int fails = 0;
  int check_count = 0;

  always #10 clk_sys = ~clk_sys;

  rds_top #(.STEP_CYCLES(STEP)) i_dut (
    .clk_sys(clk_sys), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .otp_load(otp_load), .otp_second_buck_delay(otp_second_buck_delay),
    .otp_boost_delay(otp_boost_delay), .delay_sel(delay_sel),
    .second_buck_ctrl(second_buck_ctrl), .boost_en_bit(boost_en_bit),
    .boost_pin_ctrl(boost_pin_ctrl), .enable_pin_one(pins[0]),
    .enable_pin_two(pins[1]), .enable_pin_three(pins[2]),
    .second_buck_enable(second_buck_enable), .boost_enable(boost_enable)
  );

  // ****************************************
  // helpers
  // ****************************************
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop

  // inputs always move 1 ns after the edge
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : step

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // the idle cycle after the strobe avoids a double drive in one time step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    step(1);
    reg_wr = 1'b0;
    step(1);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_addr = a;
    reg_rd = 1'b1;
    step(1);
    reg_rd = 1'b0;
    chk(reg_rdata, exp);
    step(1);
  endtask : rd

  // counts edges from the control change until the enable reaches lvl
  task automatic wait_en(input logic boost, input logic lvl, input int exp);
    int n;
    n = 0;
    while (((boost ? boost_enable : second_buck_enable) !== lvl) && n < 400) begin
      step(1);
      n++;
    end
    if (n >= 400) begin
      fails++;
      $display("Error at %0t: wait ran out, level %h", $time, lvl);
      report_and_stop();
    end
    chk(8'(n), 8'(exp));
  endtask : wait_en

  // ****************************************
  // scenarios
  // ****************************************
  task automatic test_regs;
    rd(8'h0a, 8'h00);
    rd(8'h0b, 8'h00);
    chk({6'h0, second_buck_enable, boost_enable}, 8'h00);
    wr(8'h0a, 8'ha5);
    wr(8'h0b, 8'h3c);
    wr(8'h0c, 8'hff);
    rd(8'h0a, 8'ha5);
    rd(8'h0b, 8'h3c);
    rd(8'h0c, 8'h00);
    $display("test regs done");
  endtask : test_regs

  // otp load beats a write in the same cycle, then a reset in mid-run clears
  task automatic test_otp;
    otp_second_buck_delay = 8'h21;
    otp_boost_delay = 8'h43;
    reg_addr = 8'h0a;
    reg_wdata = 8'hff;
    reg_wr = 1'b1;
    otp_load = 1'b1;
    step(1);
    reg_wr = 1'b0;
    otp_load = 1'b0;
    step(1);
    rd(8'h0a, 8'h21);
    rd(8'h0b, 8'h43);
    nrst = 1'b0;
    step(2);
    nrst = 1'b1;
    step(1);
    rd(8'h0a, 8'h00);
    rd(8'h0b, 8'h00);
    $display("test otp done");
  endtask : test_otp

  // boost control is registered once more than the second buck control
  task automatic test_rail(input logic boost, input logic dsel, input logic [3:0] on_c,
                           input logic [3:0] off_c);
    int l;
    l = dsel ? 2 * STEP : STEP;
    delay_sel = dsel;
    wr(boost ? 8'h0b : 8'h0a, {off_c, on_c});
    if (boost) begin
      boost_en_bit = 1'b1;
    end else begin
      second_buck_ctrl = 1'b1;
    end
    wait_en(boost, 1'b1, 1 + int'(boost) + int'(on_c) * l);
    if (boost) begin
      boost_en_bit = 1'b0;
    end else begin
      second_buck_ctrl = 1'b0;
    end
    wait_en(boost, 1'b0, 1 + int'(boost) + int'(off_c) * l);
    $display("test rail %0d sel %0d on %h off %h done", boost, dsel, on_c, off_c);
  endtask : test_rail

  // pins pass a synchronizer, so only the settled level is judged
  task automatic test_pins;
    logic [2:0] sel;
    delay_sel = 1'b0;
    wr(8'h0b, 8'h00);
    for (int p = 0; p < 4; p++) begin
      sel = (p == 0) ? 3'h0 : 3'(1 << (p - 1));
      boost_pin_ctrl = 2'(p);
      pins = ~sel;
      step(10);
      boost_en_bit = 1'b1;
      step(10);
      chk({7'h0, boost_enable}, {7'h0, p == 0});
      pins = 3'h7;
      step(10);
      chk({7'h0, boost_enable}, 8'h01);
      boost_en_bit = 1'b0;
      step(10);
      chk({7'h0, boost_enable}, 8'h00);
    end
    // a one-cycle low glitch on the chosen pin must not reach the rail
    boost_pin_ctrl = 2'h1;
    boost_en_bit = 1'b1;
    step(10);
    pins = 3'h6;
    step(1);
    pins = 3'h7;
    for (int c = 0; c < 8; c++) begin
      step(1);
      chk({7'h0, boost_enable}, 8'h01);
    end
    boost_en_bit = 1'b0;
    step(10);
    boost_pin_ctrl = 2'h0;
    $display("test pins done");
  endtask : test_pins

  // control dropping mid start leaves the rail off; returning mid stop keeps it on
  task automatic test_abort;
    delay_sel = 1'b0;
    wr(8'h0a, 8'h22);
    second_buck_ctrl = 1'b1;
    step(3);
    second_buck_ctrl = 1'b0;
    step(20);
    chk({7'h0, second_buck_enable}, 8'h00);
    second_buck_ctrl = 1'b1;
    wait_en(1'b0, 1'b1, 1 + 2 * STEP);
    second_buck_ctrl = 1'b0;
    step(3);
    second_buck_ctrl = 1'b1;
    step(20);
    chk({7'h0, second_buck_enable}, 8'h01);
    second_buck_ctrl = 1'b0;
    wait_en(1'b0, 1'b0, 1 + 2 * STEP);
    $display("test abort done");
  endtask : test_abort

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (12) @(posedge clk_sys);
    #1;
    nrst = 1'b1;
    step(1);
    test_regs();
    test_otp();
    foreach (codes[i]) begin
      test_rail(1'b0, i[0], codes[i], ~codes[i]);
      test_rail(1'b1, i[0], codes[i], ~codes[i]);
    end
    test_pins();
    test_abort();
    report_and_stop();
  end
endmodule : testbench
